// File: host_port_pkg.sv
// Constants, field layouts and carrier types of the disc controller host port
`default_nettype none
package host_port_pkg;
  localparam int DATA_W = 8;
  localparam int SEL_W = 3;
  localparam int NUM_PAR = 6;
  localparam int NUM_DRV = 4;
  localparam int CNT_W = 16;
  // Register pair addresses
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_DATA = 3'h1;
  localparam logic [2:0] ADDR_RES0 = 3'h2;
  // Interface status bits
  localparam int ST_REJECT = 7;
  localparam int ST_COMPLETE = 6;
  localparam int ST_BUSY = 3;
  localparam int ST_XREQ = 2;
  localparam int ST_DIR = 1;
  localparam int ST_BUSEN = 0;
  // Transaction status fields
  localparam int XS_DRV_HI = 7;
  localparam int XS_DRV_LO = 6;
  localparam int XS_TYPE_HI = 5;
  localparam int XS_TYPE_LO = 4;
  localparam int XS_CODE_HI = 3;
  localparam int XS_CODE_LO = 0;
  localparam logic [1:0] CT_GOOD = 2'h0;
  localparam logic [1:0] CT_SYSTEM = 2'h1;
  localparam logic [1:0] CT_OPERATOR = 2'h2;
  localparam logic [1:0] CT_CMD_DRIVE = 2'h3;
  // Drive number within parameter 0
  localparam int P0_DRV_HI = 7;
  localparam int P0_DRV_LO = 6;
  // Command codes
  localparam logic [7:0] CMD_ACK = 8'h00;
  localparam logic [7:0] CMD_LAST = 8'h3F;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Timing
  localparam int CLK_MHZ = 10;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYCLES = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int COPY_CYCLES = NUM_PAR;
  localparam int SYNC_W = 3 + SEL_W + DATA_W;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {3'h7, {(SEL_W + DATA_W){1'b0}}};

  typedef struct packed {
    logic [7:0] code;
    logic [NUM_PAR*8-1:0] params;
  } cmd_t;

  typedef struct packed {
    logic [7:0] xstat;
    logic [(NUM_PAR-1)*8-1:0] results;
  } done_t;

  typedef struct packed {
    logic dir;
    logic [CNT_W-1:0] count;
  } xfer_t;

  typedef enum logic [1:0] {PH_INIT, PH_RUN} phase_t;
  typedef enum logic [1:0] {CK_IDLE, CK_COPY} check_t;
endpackage : host_port_pkg
`default_nettype wire

// File: pin_sync.sv
// Two flip-flop synchroniser for host pins
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] IDLE = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] pins_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= IDLE;
      sync_q <= IDLE;
    end else begin
      meta_q <= pins_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : pin_sync
`default_nettype wire

// File: cmd_check.sv
// Command validation and parameter copy into local memory
`default_nettype none
module cmd_check (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clear_in,
  input wire logic start_in,
  input wire host_port_pkg::cmd_t cmd_in,
  input wire logic [host_port_pkg::NUM_DRV-1:0] drives_present_in,
  input wire logic [host_port_pkg::NUM_DRV-1:0] pending_in,
  output logic busy_out,
  output logic accept_out,
  output logic reject_out,
  output host_port_pkg::cmd_t cmd_out
);
  import host_port_pkg::*;

  check_t state_q, state_d;
  logic [2:0] idx_q, idx_d;
  logic [7:0] code_q, code_d;
  logic [7:0] mem_q [NUM_PAR];
  logic [7:0] mem_d [NUM_PAR];
  logic [NUM_PAR*8-1:0] src_q, src_d;
  logic acc_q, acc_d, rej_q, rej_d;
  logic [1:0] drv;
  logic bad;

  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    code_d = code_q;
    mem_d = mem_q;
    src_d = src_q;
    acc_d = 1'b0;
    rej_d = 1'b0;
    drv = src_q[(NUM_PAR-1)*8+P0_DRV_LO +: 2];
    bad = (code_q > CMD_LAST) || !drives_present_in[drv] || pending_in[drv];
    case (state_q)
      CK_IDLE: begin
        if (start_in) begin
          state_d = CK_COPY;
          idx_d = '0;
          code_d = cmd_in.code;
          src_d = cmd_in.params;
        end
      end
      CK_COPY: begin
        // One byte a cycle, as the local memory has a single port
        mem_d[idx_q] = src_q[(NUM_PAR-1-int'(idx_q))*8 +: 8];
        idx_d = idx_q + 3'h1;
        if (int'(idx_q) == COPY_CYCLES - 1) begin
          state_d = CK_IDLE;
          acc_d = !bad;
          rej_d = bad;
        end
      end
      default: state_d = CK_IDLE;
    endcase
    if (clear_in) begin
      state_d = CK_IDLE;
      acc_d = 1'b0;
      rej_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= CK_IDLE;
      idx_q <= '0;
      code_q <= BYTE_ZERO;
      src_q <= '0;
      acc_q <= 1'b0;
      rej_q <= 1'b0;
      for (int i = 0; i < NUM_PAR; i++) begin
        mem_q[i] <= BYTE_ZERO;
      end
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      code_q <= code_d;
      src_q <= src_d;
      acc_q <= acc_d;
      rej_q <= rej_d;
      mem_q <= mem_d;
    end
  end

  assign busy_out = (state_q == CK_COPY) || acc_q || rej_q;
  assign accept_out = acc_q;
  assign reject_out = rej_q;
  always_comb begin
    cmd_out.code = code_q;
    for (int i = 0; i < NUM_PAR; i++) begin
      cmd_out.params[(NUM_PAR-1-i)*8 +: 8] = mem_q[i];
    end
  end
endmodule : cmd_check
`default_nettype wire

// File: disc_controller_host_port.sv
// Host register port of the disc controller: strobes, registers, command issue
`default_nettype none
module disc_controller_host_port (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic host_reset_n_in,
  input wire logic [host_port_pkg::DATA_W-1:0] host_data_bus_in,
  output logic [host_port_pkg::DATA_W-1:0] host_data_bus_out,
  output logic host_data_bus_oe_out,
  input wire logic read_strobe_n_in,
  input wire logic write_strobe_n_in,
  input wire logic [host_port_pkg::SEL_W-1:0] register_select_in,
  output logic completion_irq_n_out,
  output logic transfer_direction_out,
  output logic bus_enable_n_out,
  output logic transfer_request_n_out,
  input wire logic self_test_pass_in,
  input wire logic [host_port_pkg::NUM_DRV-1:0] drives_present_in,
  output logic cmd_valid_out,
  output host_port_pkg::cmd_t cmd_out,
  input wire logic done_valid_in,
  input wire host_port_pkg::done_t done_in,
  input wire logic xfer_start_in,
  input wire host_port_pkg::xfer_t xfer_in,
  output logic rx_valid_out,
  output logic [host_port_pkg::DATA_W-1:0] rx_data_out,
  input wire logic [host_port_pkg::DATA_W-1:0] tx_data_in,
  output logic tx_pop_out
);
  import host_port_pkg::*;

  logic [SYNC_W-1:0] sync_s;
  logic hrst_n_s, rd_n_s, wr_n_s;
  logic [SEL_W-1:0] sel_s;
  logic [DATA_W-1:0] data_s;
  logic rd_n_q, wr_n_q, wr_rise, rd_rise;
  logic chk_busy, chk_acc, chk_rej, chk_start, busy;
  logic cmd_wr, ack_hit, data_wr, data_rd, hreset;
  phase_t phase_q, phase_d;
  logic [3:0] init_q, init_d;
  logic reject_q, reject_d, complete_q, complete_d, irq_en_q, irq_en_d;
  logic busen_q, busen_d, dir_q, dir_d;
  logic [NUM_DRV-1:0] pend_q, pend_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0] xstat_q, xstat_d;
  logic [(NUM_PAR-1)*8-1:0] res_q, res_d;
  logic [7:0] par_q [NUM_PAR];
  logic [7:0] par_d [NUM_PAR];
  logic [7:0] rdat_q, rdat_d;
  logic oe_q, oe_d, rxv_q, rxv_d, pop_q, pop_d;
  logic [7:0] rxd_q, rxd_d;
  logic [7:0] status;
  cmd_t cmd_new;

  // Address, data and strobes cross together; data is used only at strobe release
  pin_sync #(.W(SYNC_W), .IDLE(SYNC_IDLE)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pins_in({host_reset_n_in, read_strobe_n_in, write_strobe_n_in,
              register_select_in, host_data_bus_in}),
    .sync_out(sync_s)
  );
  assign {hrst_n_s, rd_n_s, wr_n_s, sel_s, data_s} = sync_s;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
    end else begin
      rd_n_q <= rd_n_s;
      wr_n_q <= wr_n_s;
    end
  end

  // Act at strobe release so each pulse is taken exactly once
  assign wr_rise = wr_n_s && !wr_n_q;
  assign rd_rise = rd_n_s && !rd_n_q;
  assign hreset = !hrst_n_s;
  assign cmd_wr = wr_rise && (sel_s == ADDR_STATUS);
  assign data_wr = wr_rise && (sel_s == ADDR_DATA);
  assign data_rd = rd_rise && (sel_s == ADDR_DATA);
  assign busy = (phase_q == PH_INIT) || chk_busy;
  assign ack_hit = (data_s == CMD_ACK);
  assign chk_start = cmd_wr && !busy && !ack_hit && !hreset;

  always_comb begin
    cmd_new.code = data_s;
    for (int i = 0; i < NUM_PAR; i++) begin
      cmd_new.params[(NUM_PAR-1-i)*8 +: 8] = par_q[i];
    end
  end

  cmd_check u_check (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clear_in(hreset),
    .start_in(chk_start),
    .cmd_in(cmd_new),
    .drives_present_in(drives_present_in),
    .pending_in(pend_q),
    .busy_out(chk_busy),
    .accept_out(chk_acc),
    .reject_out(chk_rej),
    .cmd_out(cmd_out)
  );

  always_comb begin
    status = BYTE_ZERO;
    status[ST_REJECT] = reject_q;
    status[ST_COMPLETE] = complete_q;
    status[ST_BUSY] = busy;
    status[ST_XREQ] = (cnt_q != '0);
    status[ST_DIR] = dir_q;
    status[ST_BUSEN] = busen_q;
  end

  always_comb begin
    phase_d = phase_q;
    init_d = init_q;
    reject_d = reject_q;
    complete_d = complete_q;
    irq_en_d = irq_en_q;
    pend_d = pend_q;
    cnt_d = cnt_q;
    dir_d = dir_q;
    xstat_d = xstat_q;
    res_d = res_q;
    par_d = par_q;
    rxv_d = 1'b0;
    rxd_d = rxd_q;
    pop_d = 1'b0;
    busen_d = self_test_pass_in && (phase_q == PH_RUN);
    oe_d = !rd_n_s;
    // Read mux refreshed every cycle so the bus holds the current value
    case (sel_s)
      ADDR_STATUS: rdat_d = status;
      ADDR_DATA: rdat_d = tx_data_in;
      ADDR_RES0: rdat_d = xstat_q;
      default: rdat_d = res_q[(NUM_PAR-2-(int'(sel_s)-3))*8 +: 8];
    endcase
    if (phase_q == PH_INIT) begin
      init_d = init_q + 4'h1;
      if (int'(init_q) == INIT_CYCLES - 1) begin
        phase_d = PH_RUN;
      end
    end
    if (wr_rise && (sel_s >= ADDR_RES0)) begin
      par_d[int'(sel_s) - 2] = data_s;
    end
    if (cmd_wr) begin
      if (busy) begin
        reject_d = 1'b1;
      end else if (ack_hit) begin
        complete_d = 1'b0;
        irq_en_d = 1'b1;
        reject_d = 1'b0;
      end else begin
        reject_d = 1'b0;
      end
    end
    if (chk_rej) begin
      reject_d = 1'b1;
    end
    if (chk_acc) begin
      pend_d[cmd_out.params[(NUM_PAR-1)*8+P0_DRV_LO +: 2]] = 1'b1;
    end
    if (done_valid_in) begin
      // Completion set wins over a same-cycle acknowledge
      complete_d = 1'b1;
      xstat_d = done_in.xstat;
      res_d = done_in.results;
      pend_d[done_in.xstat[XS_DRV_HI:XS_DRV_LO]] = 1'b0;
    end
    if (data_wr) begin
      rxv_d = 1'b1;
      rxd_d = data_s;
    end
    if (data_rd) begin
      pop_d = 1'b1;
    end
    if ((data_wr && !dir_q || data_rd && dir_q) && cnt_q != '0) begin
      cnt_d = cnt_q - 16'h0001;
    end
    if (xfer_start_in) begin
      dir_d = xfer_in.dir;
      cnt_d = xfer_in.count;
    end
    if (hreset) begin
      phase_d = PH_INIT;
      init_d = '0;
      reject_d = 1'b0;
      complete_d = 1'b0;
      irq_en_d = 1'b0;
      pend_d = '0;
      cnt_d = '0;
      dir_d = 1'b0;
      busen_d = 1'b0;
      rxv_d = 1'b0;
      pop_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_q <= PH_INIT;
      init_q <= '0;
      reject_q <= 1'b0;
      complete_q <= 1'b0;
      irq_en_q <= 1'b0;
      pend_q <= '0;
      cnt_q <= '0;
      dir_q <= 1'b0;
      xstat_q <= BYTE_ZERO;
      res_q <= '0;
      busen_q <= 1'b0;
      oe_q <= 1'b0;
      rdat_q <= BYTE_ZERO;
      rxv_q <= 1'b0;
      rxd_q <= BYTE_ZERO;
      pop_q <= 1'b0;
      for (int i = 0; i < NUM_PAR; i++) begin
        par_q[i] <= BYTE_ZERO;
      end
    end else begin
      phase_q <= phase_d;
      init_q <= init_d;
      reject_q <= reject_d;
      complete_q <= complete_d;
      irq_en_q <= irq_en_d;
      pend_q <= pend_d;
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      xstat_q <= xstat_d;
      res_q <= res_d;
      busen_q <= busen_d;
      oe_q <= oe_d;
      rdat_q <= rdat_d;
      rxv_q <= rxv_d;
      rxd_q <= rxd_d;
      pop_q <= pop_d;
      par_q <= par_d;
    end
  end

  assign host_data_bus_out = rdat_q;
  assign host_data_bus_oe_out = oe_q;
  // Irq follows the completion bit in the same cycle it is set, once an acknowledge has set irq_en_q
  assign completion_irq_n_out = !(complete_q && irq_en_q);
  assign transfer_direction_out = dir_q;
  assign bus_enable_n_out = !busen_q;
  assign transfer_request_n_out = (cnt_q == '0);
  assign cmd_valid_out = chk_acc;
  assign rx_valid_out = rxv_q;
  assign rx_data_out = rxd_q;
  assign tx_pop_out = pop_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  irq_with_bit_a: assert property (done_valid_in && irq_en_q && !hreset
    |=> complete_q && !completion_irq_n_out)
    else $error("irq not raised with completion bit");
  ack_clears_irq_a: assert property (cmd_wr && !busy && ack_hit && !done_valid_in && !hreset
    |=> completion_irq_n_out && irq_en_q) else $error("ack did not clear irq");
  irq_gated_a: assert property (!irq_en_q |-> completion_irq_n_out)
    else $error("irq before first ack");
  cmd_sets_busy_a: assert property (chk_start |=> status[ST_BUSY] [*6])
    else $error("busy not held during copy");
  busy_reject_a: assert property (cmd_wr && busy && !hreset |=> reject_q)
    else $error("write while busy not rejected");
  reject_no_irq_a: assert property (chk_rej && !done_valid_in && !hreset
    |=> complete_q == $past(complete_q)) else $error("reject changed completion");
  drive_on_read_a: assert property (host_data_bus_oe_out |-> $past(!rd_n_s))
    else $error("bus driven without read strobe");
  xreq_hold_a: assert property (!transfer_request_n_out && !data_wr && !data_rd
    && !xfer_start_in && !hreset |=> !transfer_request_n_out)
    else $error("request dropped early");
  write_once_a: assert property (rx_valid_out |=> !rx_valid_out)
    else $error("write acted on twice");
  init_busy_a: assert property (hreset |=> status[ST_BUSY] [*8])
    else $error("busy not shown during init");

  accept_c: cover property (chk_start ##[1:20] chk_acc);
  reject_c: cover property (chk_start ##[1:20] chk_rej);
  irq_c: cover property ($fell(completion_irq_n_out));
  xfer_done_c: cover property ($rose(transfer_request_n_out));
endmodule : disc_controller_host_port
`default_nettype wire

// File: host_bus_model.sv
// Host processor bus model driving strobes, select and data toward the port
`default_nettype none
module host_bus_model (
  input wire logic clk_in,
  input wire logic [7:0] dev_data_in,
  input wire logic dev_oe_in,
  output logic [7:0] bus_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic [2:0] sel_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] drv_q = 8'h00;
  logic host_oe_q = 1'h0;
  int stretch = 0;
  // Floating bus shows the inverse, so a stale byte never reads as valid
  assign bus_out = dev_oe_in ? dev_data_in : (host_oe_q ? drv_q : ~drv_q);
  initial begin
    rd_n_out = 1'h1;
    wr_n_out = 1'h1;
    sel_out = 3'h0;
  end
  // Same strobe signalling for programmed and block transfers
  task automatic wr(input logic [2:0] sel, input logic [7:0] val);
    @(posedge clk_in);
    sel_out <= sel;
    drv_q <= val;
    host_oe_q <= 1'h1;
    wr_n_out <= 1'h0;
    repeat (3 + stretch) @(posedge clk_in);
    wr_n_out <= 1'h1;
    repeat (3) @(posedge clk_in);
    host_oe_q <= 1'h0;
  endtask : wr
  task automatic rd(input logic [2:0] sel, output logic [7:0] val);
    @(posedge clk_in);
    sel_out <= sel;
    @(posedge clk_in);
    rd_n_out <= 1'h0;
    repeat (5 + stretch) @(posedge clk_in);
    val = bus_out;
    rd_n_out <= 1'h1;
    repeat (4) @(posedge clk_in);
  endtask : rd
endmodule : host_bus_model
`default_nettype wire

// File: testbench.sv
// Self-checking bench of the disc controller host port
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import host_port_pkg::*;
  typedef struct packed {
    logic [2:0] sel;
    logic [7:0] exp;
  } row_t;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic host_reset_n = 1'h1;
  logic [7:0] bus, dout, s, rx_data, rx_seen;
  logic oe, rd_n, wr_n, irq_n, dir, ben_n, xreq_n, cmd_valid, rx_valid, tx_pop;
  logic [2:0] sel;
  logic [3:0] drv_mask = 4'hF;
  logic self_ok = 1'h1;
  logic done_valid = 1'h0;
  logic xfer_start = 1'h0;
  logic [7:0] tx_data = 8'hC3;
  cmd_t cmd, cmd_seen;
  done_t done = '0;
  xfer_t xfer = '0;
  row_t rows [6] = '{'{3'h2, 8'h5B}, '{3'h3, 8'h11}, '{3'h4, 8'h22}, '{3'h5, 8'h33},
    '{3'h6, 8'h44}, '{3'h7, 8'h55}};
  logic [15:0] bad [3] = '{16'h4000, 16'h01C0, 16'h0100};
  int err_total = 0;
  int comparisons = 0;
  int n_cmd = 0;
  int n_rx = 0;
  int n_pop = 0;
  initial begin
    forever #50 clk_in = ~clk_in;
  end
  disc_controller_host_port dut (.clk_in(clk_in), .rst_in(rst_in),
    .host_reset_n_in(host_reset_n), .host_data_bus_in(bus), .host_data_bus_out(dout),
    .host_data_bus_oe_out(oe), .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n),
    .register_select_in(sel), .completion_irq_n_out(irq_n), .transfer_direction_out(dir),
    .bus_enable_n_out(ben_n), .transfer_request_n_out(xreq_n), .self_test_pass_in(self_ok),
    .drives_present_in(drv_mask), .cmd_valid_out(cmd_valid), .cmd_out(cmd),
    .done_valid_in(done_valid), .done_in(done), .xfer_start_in(xfer_start),
    .xfer_in(xfer), .rx_valid_out(rx_valid), .rx_data_out(rx_data), .tx_data_in(tx_data),
    .tx_pop_out(tx_pop));
  host_bus_model host (.clk_in(clk_in), .dev_data_in(dout), .dev_oe_in(oe), .bus_out(bus),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .sel_out(sel));
  always @(posedge clk_in) begin
    if (cmd_valid === 1'h1) begin
      n_cmd++;
      cmd_seen = cmd;
    end
    if (rx_valid === 1'h1) begin
      n_rx++;
      rx_seen = rx_data;
    end
    if (tx_pop === 1'h1) n_pop++;
  end
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic chk_v(input logic [55:0] got, input logic [55:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_v
  task automatic chk_b(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_b
  // Settle past the edge so registered outputs are compared, not raced
  task automatic tick;
    repeat (2) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic idle_wait;
    logic [7:0] v;
    for (int i = 0; i < 20; i++) begin
      host.rd(ADDR_STATUS, v);
      if (v[ST_BUSY] === 1'h0) return;
    end
    err_total++;
    final_report();
  endtask : idle_wait
  task automatic st(input logic [7:0] exp);
    logic [7:0] v;
    host.rd(ADDR_STATUS, v);
    chk_v(v, exp);
  endtask : st
  task automatic issue(input logic [7:0] code, input logic [7:0] p0);
    host.wr(ADDR_RES0, p0);
    for (int i = 1; i < NUM_PAR; i++) host.wr(3'(i + 2), 8'(8'hA0 + i));
    host.wr(ADDR_STATUS, code);
    idle_wait();
  endtask : issue
  task automatic fin(input logic [7:0] xs);
    @(posedge clk_in);
    done_valid <= 1'h1;
    done <= {xs, 40'h1122334455};
    @(posedge clk_in);
    done_valid <= 1'h0;
    tick();
  endtask : fin
  task automatic ack;
    host.wr(ADDR_STATUS, CMD_ACK);
    idle_wait();
  endtask : ack
  task automatic xfer_go(input logic d, input logic [15:0] n);
    @(posedge clk_in);
    xfer_start <= 1'h1;
    xfer <= {d, n};
    @(posedge clk_in);
    xfer_start <= 1'h0;
    tick();
  endtask : xfer_go
  initial begin
    repeat (3) @(posedge clk_in);
    #1;
    chk_v({oe, irq_n, dir, ben_n, xreq_n}, 56'h0B);
    repeat (3) @(posedge clk_in);
    rst_in <= 1'h0;
    host.rd(ADDR_STATUS, s);
    chk_b(s[ST_BUSY], 1'h1);
    idle_wait();
    st(8'h01);
    chk_b(ben_n, 1'h0);
    issue(8'h01, 8'h40);
    chk_v(56'(n_cmd), 56'h1);
    chk_v(cmd_seen, {8'h01, 8'h40, 40'hA1A2A3A4A5});
    fin(8'h5B);
    st(8'h41);
    chk_b(irq_n, 1'h1);
    foreach (rows[i]) begin
      host.rd(rows[i].sel, s);
      chk_v(s, rows[i].exp);
    end
    ack();
    st(8'h01);
    issue(8'h02, 8'h80);
    fin(8'h80);
    chk_b(irq_n, 1'h0);
    ack();
    chk_b(irq_n, 1'h1);
    drv_mask <= 4'h7;
    issue(8'h01, 8'h00);
    foreach (bad[i]) begin
      issue(bad[i][15:8], bad[i][7:0]);
      st(8'h81);
      chk_b(irq_n, 1'h1);
      ack();
    end
    chk_v(56'(n_cmd), 56'h3);
    fin(8'h00);
    ack();
    // Second write lands inside the first one's validation window
    host.wr(ADDR_STATUS, 8'h03);
    host.wr(ADDR_STATUS, 8'h03);
    idle_wait();
    chk_v(56'(n_cmd), 56'h4);
    st(8'h81);
    fin(8'h00);
    ack();
    xfer_go(1'h1, 16'h0002);
    chk_v({dir, xreq_n}, 56'h2);
    st(8'h07);
    host.rd(ADDR_DATA, s);
    chk_v(s, 8'hC3);
    chk_b(oe, 1'h0);
    chk_b(xreq_n, 1'h0);
    host.stretch = 4;
    host.rd(ADDR_DATA, s);
    tick();
    chk_v(56'(n_pop), 56'h2);
    chk_b(xreq_n, 1'h1);
    xfer_go(1'h0, 16'h0003);
    chk_v({dir, xreq_n}, 56'h0);
    for (int i = 0; i < 4; i++) begin
      host.wr(ADDR_DATA, 8'(8'h81 >> i));
      tick();
      chk_v(rx_seen, 8'(8'h81 >> i));
      chk_b(xreq_n, 1'(i >= 2));
    end
    chk_v(56'(n_rx), 56'h4);
    host.stretch = 0;
    @(posedge clk_in);
    host_reset_n <= 1'h0;
    repeat (5) @(posedge clk_in);
    host_reset_n <= 1'h1;
    host.rd(ADDR_STATUS, s);
    chk_b(s[ST_BUSY], 1'h1);
    idle_wait();
    issue(8'h01, 8'h40);
    fin(8'h40);
    chk_b(irq_n, 1'h1);
    // Failed self test must withdraw bus enable on pin and status bit
    @(posedge clk_in);
    self_ok <= 1'h0;
    tick();
    chk_b(ben_n, 1'h1);
    st(8'h40);
    final_report();
  end
endmodule : testbench
`default_nettype wire
